// ### verilog/dph_ctrl.sv
`timescale 1ns/10ps
// Contract
// - fast power-down exit: wait 2 clocks before a read, 3 at top grade.
// - slow power-down exit: wait grade count minus additive latency before read.
// - mode bit 12 picks fast exit at 0, slow low-power exit at 1.
// - clock enable stays at each level at least 3 clocks.
// - refresh average at most 7.8 us, 3.9 us when hot.
// - no more than eight refreshes outstanding.
// - at least two clocks from write completion to read.
// - times turned into clocks round up to whole cycles; the refresh interval rounds down instead.
// - complement strobe is the inverse of the strobe while driven.
// - strobe goes from released to driven low before the first write edge.
module dph_ctrl (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // user request
    input  wire logic                 req_valid,
    input  wire dph_pkg::dph_req_t    req_cmd,
    input  wire logic [13:0]          req_addr,
    input  wire logic [1:0]           req_bank,
    output logic                      req_ack,
    // user configuration, and the synchronized read strobe back
    input  wire logic                 low_power_pd_mode,
    input  wire logic                 ext_temp,
    input  wire logic [2:0]           speed_grade,
    input  wire logic [2:0]           additive_latency,
    output logic                      rd_strobe,
    // memory pins
    output logic                      mem_ck,
    output logic                      mem_ck_n,
    output logic                      mem_cke,
    output logic                      mem_cs_n,
    output logic                      mem_ras_n,
    output logic                      mem_cas_n,
    output logic                      mem_we_n,
    output logic [13:0]               mem_addr,
    output logic [1:0]                mem_ba,
    input  wire logic                 dqs_i,
    output logic                      dqs_o,
    output logic                      dqs_oe,
    output logic                      dqs_n_o,
    output logic                      dqs_n_oe
);
    typedef struct packed {
        dph_pkg::dph_st_t  st;
        logic              phase;
        logic              ck;
        logic              ck_n;
        logic              cke;
        logic [3:0]        cmd;
        logic [13:0]       addr;
        logic [1:0]        ba;
        logic              dqs;
        logic              dqs_n;
        logic              dqs_oe;
        logic              wcnt;
        logic signed [4:0] debt;
        logic [7:0]        refi;
        logic              low_pwr;
        logic              ack;
        logic              sync1;
        logic              sync2;
    } dph_state_t;

    dph_state_t s_reg;
    dph_state_t s_next;
    logic       ld_cke;
    logic       ld_wtr;
    logic       ld_exit;
    logic [7:0] exit_val;
    logic       force_ref;

    dph_tmr_if tmr_bus[dph_pkg::TMR_NUM] ();

    genvar gi;
    generate
        for (gi = 0; gi < dph_pkg::TMR_NUM; gi++)
        begin : g_tmr
            assign tmr_bus[gi].tick = s_reg.phase;
            dph_gap_timer u_tmr (
                .core_clk (core_clk),
                .nrst     (nrst),
                .port     (tmr_bus[gi])
            );
        end
    endgenerate

    assign tmr_bus[dph_pkg::TMR_CKE].load  = ld_cke;
    assign tmr_bus[dph_pkg::TMR_CKE].val   = 8'(dph_pkg::CKE_MIN_CK);
    assign tmr_bus[dph_pkg::TMR_WTR].load  = ld_wtr;
    assign tmr_bus[dph_pkg::TMR_WTR].val   = 8'(dph_pkg::WTR_CK);
    assign tmr_bus[dph_pkg::TMR_EXIT].load = ld_exit;
    assign tmr_bus[dph_pkg::TMR_EXIT].val  = exit_val;

    // refresh must go out before the debt can pass the posting limit
    assign force_ref = (s_reg.debt >= 5'(dph_pkg::POST_MAX - 1));

    always_comb
    begin
        s_next   = s_reg;
        ld_cke   = 1'b0;
        ld_wtr   = 1'b0;
        ld_exit  = 1'b0;
        exit_val = dph_pkg::exit_need(s_reg.low_pwr, speed_grade, additive_latency);
        s_next.phase = ~s_reg.phase;
        s_next.ck    = ~s_reg.phase;
        s_next.ck_n  = s_reg.phase;
        s_next.ack   = 1'b0;
        s_next.sync1 = dqs_i;
        s_next.sync2 = s_reg.sync1;
        if (s_reg.phase)
        begin
            s_next.cmd = dph_pkg::CMD_NOP;
            if (s_reg.refi == 8'h00)
            begin
                s_next.refi = ext_temp ? 8'(dph_pkg::REFI_EXT_CK - 1) :
                                         8'(dph_pkg::REFI_NORM_CK - 1);
                s_next.debt = s_reg.debt + 5'sh01;
            end
            else
                s_next.refi = s_reg.refi - 8'h01;
        end
        unique case (s_reg.st)
            dph_pkg::ST_IDLE:
            begin
                if (s_reg.phase && force_ref)
                begin
                    s_next.cmd  = dph_pkg::CMD_REFRESH;
                    s_next.debt = s_next.debt - 5'sh01;
                end
                else if (s_reg.phase && req_valid)
                begin
                    s_next.addr = req_addr;
                    s_next.ba   = req_bank;
                    unique case (req_cmd)
                        dph_pkg::REQ_READ:
                        begin
                            if (tmr_bus[dph_pkg::TMR_WTR].zero &&
                                tmr_bus[dph_pkg::TMR_EXIT].zero)
                            begin
                                s_next.cmd = dph_pkg::CMD_READ;
                                s_next.ack = 1'b1;
                            end
                        end
                        dph_pkg::REQ_WRITE:
                        begin
                            s_next.cmd = dph_pkg::CMD_WRITE;
                            s_next.ack = 1'b1;
                            s_next.st  = dph_pkg::ST_WPRE;
                        end
                        dph_pkg::REQ_REFRESH:
                        begin
                            // pulling in is limited to the same depth
                            if (s_reg.debt > -5'(dph_pkg::POST_MAX))
                            begin
                                s_next.cmd  = dph_pkg::CMD_REFRESH;
                                s_next.debt = s_next.debt - 5'sh01;
                                s_next.ack  = 1'b1;
                            end
                        end
                        dph_pkg::REQ_PD_ENTER:
                        begin
                            if (tmr_bus[dph_pkg::TMR_CKE].zero)
                            begin
                                s_next.cke = 1'b0;
                                ld_cke     = 1'b1;
                                s_next.ack = 1'b1;
                                s_next.st  = dph_pkg::ST_PDOWN;
                            end
                        end
                        dph_pkg::REQ_MODE:
                        begin
                            s_next.cmd = dph_pkg::CMD_MODE;
                            s_next.addr[dph_pkg::MODE_PD_BIT] = low_power_pd_mode;
                            s_next.low_pwr = low_power_pd_mode;
                            s_next.ack = 1'b1;
                        end
                        default:
                            s_next.ack = 1'b1;
                    endcase
                end
            end
            dph_pkg::ST_PDOWN:
            begin
                if (s_reg.phase && tmr_bus[dph_pkg::TMR_CKE].zero &&
                    (force_ref || (req_valid && req_cmd == dph_pkg::REQ_PD_EXIT)))
                begin
                    s_next.cke = 1'b1;
                    ld_cke     = 1'b1;
                    ld_exit    = 1'b1;
                    s_next.ack = req_valid && req_cmd == dph_pkg::REQ_PD_EXIT;
                    s_next.st  = dph_pkg::ST_IDLE;
                end
            end
            dph_pkg::ST_WPRE:
            begin
                if (s_reg.phase)
                begin
                    if (!s_reg.dqs_oe)
                    begin
                        s_next.dqs_oe = 1'b1;
                        s_next.dqs    = 1'b0;
                    end
                    else
                    begin
                        s_next.wcnt = 1'b0;
                        s_next.st   = dph_pkg::ST_WBURST;
                    end
                end
            end
            dph_pkg::ST_WBURST:
            begin
                s_next.dqs = ~s_reg.dqs;
                if (s_reg.phase)
                begin
                    s_next.wcnt = 1'b1;
                    if (s_reg.wcnt)
                        s_next.st = dph_pkg::ST_WPOST;
                end
            end
            dph_pkg::ST_WPOST:
            begin
                if (s_reg.phase)
                begin
                    s_next.dqs_oe = 1'b0;
                    s_next.dqs    = 1'b0;
                    ld_wtr        = 1'b1;
                    s_next.st     = dph_pkg::ST_IDLE;
                end
            end
            default:
                s_next.st = dph_pkg::ST_IDLE;
        endcase
        s_next.dqs_n = ~s_next.dqs;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_reg       <= '0;
            s_reg.st    <= dph_pkg::ST_IDLE;
            s_reg.ck_n  <= 1'b1;
            s_reg.cke   <= 1'b1;
            s_reg.cmd   <= dph_pkg::CMD_NOP;
            s_reg.dqs_n <= 1'b1;
            s_reg.refi  <= 8'(dph_pkg::REFI_EXT_CK - 1);
        end
        else
            s_reg <= s_next;
    end

    assign req_ack   = s_reg.ack;
    assign rd_strobe = s_reg.sync2;
    assign mem_ck    = s_reg.ck;
    assign mem_ck_n  = s_reg.ck_n;
    assign mem_cke   = s_reg.cke;
    assign mem_cs_n  = s_reg.cmd[3];
    assign mem_ras_n = s_reg.cmd[2];
    assign mem_cas_n = s_reg.cmd[1];
    assign mem_we_n  = s_reg.cmd[0];
    assign mem_addr  = s_reg.addr;
    assign mem_ba    = s_reg.ba;
    assign dqs_o     = s_reg.dqs;
    assign dqs_oe    = s_reg.dqs_oe;
    assign dqs_n_o   = s_reg.dqs_n;
    assign dqs_n_oe  = s_reg.dqs_oe;

    // helper: core cycles since clock enable rose, and the wait owed then
    logic [7:0] exit_age;
    logic [7:0] exit_owed;
    logic       rd_cmd;
    assign rd_cmd = (s_reg.cmd == dph_pkg::CMD_READ);
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exit_age  <= 8'hff;
            exit_owed <= 8'h00;
        end
        else if (ld_exit)
        begin
            exit_age  <= 8'h00;
            exit_owed <= exit_val;
        end
        else if (exit_age != 8'hff)
            exit_age <= exit_age + 8'h01;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence cke_moved_s;
        $changed(s_reg.cke);
    endsequence
    sequence preamble_s;
        !s_reg.dqs ##1 !s_reg.dqs;
    endsequence
    sequence write_done_s;
        $fell(s_reg.dqs_oe);
    endsequence

    cke_width_a: assert property (cke_moved_s |=> $stable(s_reg.cke)[*5])
        else $error("clock enable changed too soon");
    strobe_inv_a: assert property (s_reg.dqs_oe |-> s_reg.dqs_n == ~s_reg.dqs)
        else $error("complement strobe not inverted");
    wr_preamble_a: assert property ($rose(s_reg.dqs_oe) |-> preamble_s)
        else $error("write preamble not low");
    wtr_gap_a: assert property (write_done_s |-> !rd_cmd[*4])
        else $error("read too close after write");
    exit_read_a: assert property (rd_cmd && exit_age != 8'hff |->
                                  exit_age >= {exit_owed[6:0], 1'b0})
        else $error("read too soon after power-down exit");
    slow_exit_a: assert property (ld_exit && s_reg.low_pwr |->
                                  exit_val == dph_pkg::exit_need(1'b1, speed_grade,
                                                                 additive_latency))
        else $error("slow exit wait wrong");
    mode_bit_a: assert property (s_reg.cmd == dph_pkg::CMD_MODE |->
                                 s_reg.low_pwr == s_reg.addr[dph_pkg::MODE_PD_BIT])
        else $error("exit mode not tracked");
    debt_limit_a: assert property (s_reg.debt <= 5'sh08 && s_reg.debt >= -5'sh08)
        else $error("refresh debt out of range");
    refi_span_a: assert property (s_reg.refi < 8'(dph_pkg::REFI_NORM_CK))
        else $error("refresh interval too long");
endmodule : dph_ctrl

// ### inc/dph_pkg.sv
package dph_pkg;
    // link clock is core_clk divided by two
    localparam int          CORE_PS         = 50000;
    localparam int          CK_DIV          = 2;
    localparam int          CK_PS           = CORE_PS * CK_DIV;
    // write completion to read, time and floor in link clocks
    localparam int          WTR_PS          = 7500;
    localparam int          WTR_FLOOR_CK    = 2;
    localparam int          WTR_CEIL_CK     = (WTR_PS + CK_PS - 1) / CK_PS;
    localparam int          WTR_CK          = (WTR_CEIL_CK > WTR_FLOOR_CK) ?
                                              WTR_CEIL_CK : WTR_FLOOR_CK;
    localparam int          CKE_MIN_CK      = 3;
    // refresh interval is a longest time, so it rounds down
    localparam int          REFI_NORM_PS    = 7800000;
    localparam int          REFI_EXT_PS     = 3900000;
    localparam int          REFI_NORM_CK    = REFI_NORM_PS / CK_PS;
    localparam int          REFI_EXT_CK     = REFI_EXT_PS / CK_PS;
    localparam int          POST_MAX        = 8;
    localparam int          FAST_EXIT_CK    = 2;
    localparam int          FAST_EXIT_TOP   = 3;
    localparam logic [2:0]  GRADE_TOP       = 3'h4;
    localparam int          MODE_PD_BIT     = 12;
    // chip select, row, column, write strobes
    localparam logic [3:0]  CMD_NOP         = 4'h7;
    localparam logic [3:0]  CMD_READ        = 4'h5;
    localparam logic [3:0]  CMD_WRITE       = 4'h4;
    localparam logic [3:0]  CMD_REFRESH     = 4'h1;
    localparam logic [3:0]  CMD_MODE        = 4'h0;
    localparam int          TMR_CKE         = 0;
    localparam int          TMR_WTR         = 1;
    localparam int          TMR_EXIT        = 2;
    localparam int          TMR_NUM         = 3;

    typedef enum logic [2:0] {
        REQ_READ     = 3'h0,
        REQ_WRITE    = 3'h1,
        REQ_REFRESH  = 3'h2,
        REQ_PD_ENTER = 3'h3,
        REQ_PD_EXIT  = 3'h4,
        REQ_MODE     = 3'h5
    } dph_req_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_PDOWN  = 3'h1,
        ST_WPRE   = 3'h2,
        ST_WBURST = 3'h3,
        ST_WPOST  = 3'h4
    } dph_st_t;

    // slow exit count per grade, slowest first
    function automatic logic [7:0] slow_base(input logic [2:0] grade);
        case (grade)
            3'h0:    slow_base = 8'h06;
            3'h1:    slow_base = 8'h07;
            3'h2:    slow_base = 8'h08;
            3'h3:    slow_base = 8'h08;
            default: slow_base = 8'h0a;
        endcase
    endfunction : slow_base

    // link clocks from power-down exit to the first read
    function automatic logic [7:0] exit_need(input logic       low_pwr,
                                             input logic [2:0] grade,
                                             input logic [2:0] al);
        logic [7:0] base;
        base = slow_base(grade);
        if (!low_pwr)
            exit_need = (grade == GRADE_TOP) ? 8'(FAST_EXIT_TOP) : 8'(FAST_EXIT_CK);
        else if (base > {5'h00, al})
            exit_need = base - {5'h00, al};
        else
            exit_need = 8'h01;
    endfunction : exit_need
endpackage : dph_pkg

// ### inc/dph_tmr_if.sv
`timescale 1ns/10ps
interface dph_tmr_if;
    logic       load;
    logic [7:0] val;
    logic       tick;
    logic       zero;
    modport ctl (output load, output val, output tick, input zero);
    modport tmr (input load, input val, input tick, output zero);
endinterface : dph_tmr_if

// ### verilog/dph_gap_timer.sv
`timescale 1ns/10ps
module dph_gap_timer (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // load, tick and done
    dph_tmr_if.tmr    port
);
    typedef struct packed {
        logic [7:0] cnt;
    } dph_tmr_state_t;

    dph_tmr_state_t s_reg;
    dph_tmr_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (port.load)
            s_next.cnt = port.val;
        else if (port.tick && s_reg.cnt != 8'h00)
            s_next.cnt = s_reg.cnt - 8'h01;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign port.zero = (s_reg.cnt == 8'h00);
endmodule : dph_gap_timer

// ### testbench/dph_mem_model.sv
`timescale 1ns/10ps
module dph_mem_model (
    // clock and command pins
    input  wire logic        mem_ck,
    input  wire logic        mem_cke,
    input  wire logic [3:0]  cmd,
    input  wire logic [13:0] mem_addr,
    // strobe pins
    input  wire logic        dqs_o,
    input  wire logic        dqs_oe,
    input  wire logic        dqs_n_o,
    input  wire logic        dqs_n_oe,
    output logic             dqs_i,
    // board setup, and the fault count back
    input  wire logic        ext_temp,
    input  wire logic [2:0]  speed_grade,
    input  wire logic [2:0]  additive_latency,
    output logic [7:0]       viol
);
    logic       low_pwr   = 1'b0;
    logic       cke_q     = 1'b1;
    logic       oe_q      = 1'b0;
    logic [7:0] base;
    logic [7:0] need;
    int         cke_run   = 100;
    int         exit_run  = 100;
    int         refi_run  = 0;
    int         debt      = 0;
    int         rd_left   = 0;
    realtime    oe_fall_t = 0.0;

    initial
    begin
        dqs_i = 1'b1;
        viol = 8'h00;
    end

    always_comb
    begin
        case (speed_grade)
            3'h0:    base = 8'h06;
            3'h1:    base = 8'h07;
            3'h2:    base = 8'h08;
            3'h3:    base = 8'h08;
            default: base = 8'h0a;
        endcase
        if (!low_pwr)
            need = (speed_grade == 3'h4) ? 8'h03 : 8'h02;
        else
            need = (base > {5'h00, additive_latency}) ? base - {5'h00, additive_latency} : 8'h01;
    end

    // pins are looked at just after each link clock edge, once settled
    always @(mem_ck)
    begin
        #1;
        // read strobe: low preamble, four edges, then released
        if (rd_left > 0)
        begin
            dqs_i = (rd_left == 6) ? 1'b0 : ~dqs_i;
            rd_left--;
        end
        if (dqs_oe === 1'b1 && !oe_q && dqs_o !== 1'b0) viol++;
        if (dqs_oe !== dqs_n_oe || (dqs_oe === 1'b1 && dqs_n_o !== ~dqs_o)) viol++;
        if (oe_q && dqs_oe !== 1'b1) oe_fall_t = $realtime;
        oe_q = (dqs_oe === 1'b1);
        if (mem_ck === 1'b1)
        begin
            cke_run++;
            exit_run++;
            refi_run++;
            if (mem_cke !== cke_q)
            begin
                if (cke_run < dph_pkg::CKE_MIN_CK) viol++;
                cke_run = 0;
                if (mem_cke === 1'b1) exit_run = 0;
            end
            cke_q = mem_cke;
            if (refi_run >= (ext_temp ? 3900000 : 7800000) / dph_pkg::CK_PS)
            begin
                refi_run = 0;
                debt++;
            end
            if (cmd === dph_pkg::CMD_REFRESH) debt--;
            if (debt > 8) viol++;
            if (cmd === dph_pkg::CMD_MODE) low_pwr = mem_addr[dph_pkg::MODE_PD_BIT];
            if (cmd === dph_pkg::CMD_READ)
            begin
                if (exit_run < need) viol++;
                if (oe_q || $realtime - oe_fall_t < 2.0 * dph_pkg::CK_PS / 1000.0) viol++;
                rd_left = 6;
            end
        end
    end
endmodule : dph_mem_model

// ### testbench/dph_ctrl_bench.sv
`timescale 1ns/10ps
module dph_ctrl_bench;
    logic              core_clk, nrst, req_valid, low_power_pd_mode, ext_temp;
    dph_pkg::dph_req_t req_cmd;
    logic [13:0]       req_addr, mem_addr;
    logic [1:0]        req_bank, mem_ba;
    logic [2:0]        speed_grade, additive_latency;
    logic              req_ack, rd_strobe, mem_ck, mem_ck_n, mem_cke;
    logic              mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic              dqs_i, dqs_o, dqs_oe, dqs_n_o, dqs_n_oe;
    logic [7:0]        viol;
    logic [3:0]        cmd;
    logic              cke_q, oe_q, dq_q;
    logic [1:0]        pre_val;
    int                n_errors, n_checks, cyc, cke_rise, rd_at, oe_fall, n_tog, n_ref;
    int                n_rdlo = 0;
    int                cke_run = 100;

    assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

    dph_ctrl dut (
        .core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_bank(req_bank), .req_ack(req_ack),
        .low_power_pd_mode(low_power_pd_mode), .ext_temp(ext_temp),
        .speed_grade(speed_grade), .additive_latency(additive_latency),
        .rd_strobe(rd_strobe), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n), .mem_cke(mem_cke),
        .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_ba(mem_ba), .dqs_i(dqs_i),
        .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_n_o(dqs_n_o), .dqs_n_oe(dqs_n_oe)
    );

    dph_mem_model mem (
        .mem_ck(mem_ck), .mem_cke(mem_cke), .cmd(cmd), .mem_addr(mem_addr),
        .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_n_o(dqs_n_o), .dqs_n_oe(dqs_n_oe),
        .dqs_i(dqs_i), .ext_temp(ext_temp), .speed_grade(speed_grade),
        .additive_latency(additive_latency), .viol(viol)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // pin monitor; the memory samples commands where the link clock rises
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        cke_q <= mem_cke;
        oe_q <= dqs_oe;
        dq_q <= dqs_o;
        if (mem_cke === 1'b1 && cke_q === 1'b0) cke_rise <= cyc;
        if (mem_ck === 1'b0 && cmd === dph_pkg::CMD_READ) rd_at <= cyc;
        if (mem_ck === 1'b0 && cmd === dph_pkg::CMD_REFRESH) n_ref <= n_ref + 1;
        if (dqs_oe === 1'b1 && oe_q === 1'b0) pre_val <= {dqs_o, dqs_n_o};
        if (dqs_oe === 1'b0 && oe_q === 1'b1) oe_fall <= cyc;
        if (dqs_oe === 1'b1 && oe_q === 1'b1 && dqs_o !== dq_q) n_tog <= n_tog + 1;
        if (rd_strobe === 1'b0) n_rdlo <= n_rdlo + 1;
        if (nrst === 1'b1 && cke_q !== mem_cke)
        begin
            check({31'h0, cke_run >= 2 * 3}, 32'h1, "clock enable pulse too short");
            cke_run <= 1;
        end
        else
            cke_run <= cke_run + 1;
    end

    task automatic issue(input dph_pkg::dph_req_t c, input logic [13:0] a);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        @(posedge core_clk);
        while (req_ack !== 1'b1 && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        check({31'h0, req_ack}, 32'h1, "request not acknowledged");
        req_valid <= 1'b0;
        // let one edge pass so a following request never reassigns valid in this step
        @(posedge core_clk);
    endtask : issue

    task automatic pd_exit_case(input logic lp, input logic [2:0] g, input logic [2:0] al,
                                input int need);
        int gap;
        low_power_pd_mode <= lp;
        speed_grade <= g;
        additive_latency <= al;
        issue(dph_pkg::REQ_REFRESH, 14'h0000);
        issue(dph_pkg::REQ_MODE, 14'h0000);
        issue(dph_pkg::REQ_PD_ENTER, 14'h0000);
        issue(dph_pkg::REQ_PD_EXIT, 14'h0000);
        issue(dph_pkg::REQ_READ, 14'h0123);
        repeat (4) @(posedge core_clk);
        gap = rd_at - cke_rise;
        check({31'h0, gap >= 2 * need - 1}, 32'h1, "read too soon after exit");
        check({31'h0, gap <= 2 * need + 4}, 32'h1, "read too late after exit");
    endtask : pd_exit_case

    task automatic write_then_read;
        int t0;
        int l0;
        t0 = n_tog;
        issue(dph_pkg::REQ_WRITE, 14'h0040);
        l0 = n_rdlo;
        issue(dph_pkg::REQ_READ, 14'h0040);
        repeat (12) @(posedge core_clk);
        check(32'(n_rdlo - l0), 32'h3, "read strobe low cycles");
        check(32'(n_tog - t0), 32'h4, "write strobe edge count");
        check({30'h0, pre_val}, 32'h1, "write preamble not driven low");
        check({31'h0, rd_at - oe_fall >= 2 * 2}, 32'h1, "read too soon after write");
    endtask : write_then_read

    task automatic refresh_rate(input logic hot, input int ticks);
        int r0;
        int got;
        ext_temp <= hot;
        r0 = n_ref;
        repeat (ticks * (hot ? 3900 : 7800) / 50) @(posedge core_clk);
        got = n_ref - r0;
        check({31'h0, got >= ticks - 17 && got <= ticks + 17}, 32'h1, "refresh count");
    endtask : refresh_rate

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        close_out();
    end

    initial
    begin
        {nrst, req_valid, low_power_pd_mode, ext_temp} = 4'h0;
        req_cmd = dph_pkg::REQ_READ;
        {req_addr, req_bank, speed_grade, additive_latency} = '0;
        {n_errors, n_checks, cyc, cke_rise, rd_at, oe_fall, n_tog, n_ref} = '0;
        repeat (10) @(posedge core_clk);
        check({28'h0, mem_cke, dqs_oe, dqs_n_oe, req_ack}, 32'h8, "reset pin state");
        check({28'h0, cmd}, {28'h0, dph_pkg::CMD_NOP}, "reset command");
        check(32'(dph_pkg::WTR_CK), 32'h2, "write to read rounding");
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        pd_exit_case(1'b0, 3'h0, 3'h0, 2);
        pd_exit_case(1'b0, 3'h4, 3'h0, 3);
        pd_exit_case(1'b1, 3'h0, 3'h0, 6);
        pd_exit_case(1'b1, 3'h1, 3'h2, 5);
        pd_exit_case(1'b1, 3'h2, 3'h0, 8);
        pd_exit_case(1'b1, 3'h3, 3'h1, 7);
        pd_exit_case(1'b1, 3'h4, 3'h3, 7);
        write_then_read();
        refresh_rate(1'b0, 20);
        refresh_rate(1'b1, 40);
        check({24'h0, viol}, 32'h0, "memory saw a timing fault");
        close_out();
    end
endmodule : dph_ctrl_bench
